// ==== core/rcf_reset_cause.v ====
// Reset-cause flag register, time-out and power-down flags, and the
// program counter selection that follows each reset or wake-up event.
// Assumes event inputs are pulses or levels from any clock; each is
// synchronised here before use.
//
// Summary of operation
// (R1) Every reset event updates cause flags; power-on, brown-out, watchdog and in-sleep pin resets also update status.
// (R2) Power-on sets the time-out flag to one.
// (R3) Power-on sets the power-down flag to one.
// (R4) Power-on clears the power-on flag; firmware writes it back to one.
// (R5) Brown-out clears brown-out flag, keeps power-on flag.
// (R6) Brown-out flag also reads zero after power-on.
// (R7) Watchdog reset clears watchdog and time-out flags, restarts at zero.
// (R8) Watchdog wake clears time-out and power-down, continues at PC plus one.
// (R9) Interrupt wake sets time-out, clears power-down, continues at PC+1.
// (R10) With interrupts enabled, run next instruction then vector 0004h.
// (R11) Pin reset when running clears pin flag, restarts at zero.
// (R12) Pin reset in sleep also sets time-out and clears power-down.
// (R13) Reset instruction clears its flag and restarts at zero.
// (R14) Firmware may write ones into watchdog, pin and instruction flags.
// (R15) Stack overflow sets its flag; firmware clears by writing zero.
// (R16) Stack underflow sets its flag; firmware clears by writing zero.
// (R17) Stack faults reset to zero only when stack reset is enabled.
// (R18) Power-on loads cause register with 0001 1100.
// (R19) Brown-out loads cause register with 0001 11u0.
// (R20) Bit 5 of the cause register always reads zero.
// (R21) Either brown-out detector clears the brown-out flag.
// (R22) Each source is edge-caught once; writes land on the next edge.
`timescale 1ns/1ps
`include "rcf_consts.vh"
module rcf_reset_cause (
   input  wire                    clk_sys,
   input  wire                    rst_n,
   input  wire [`RCF_ADDR_W-1:0]  reg_addr,
   input  wire [7:0]              reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [7:0]              reg_rdata,
   input  wire                    por_event,
   input  wire                    bor_event,
   input  wire                    low_power_brownout_event,
   input  wire                    watchdog_event,
   input  wire                    pin_event,
   input  wire                    reset_instr_event,
   input  wire                    stack_overflow_event,
   input  wire                    stack_underflow_event,
   input  wire                    interrupt_wake_event,
   input  wire                    sleeping,
   input  wire                    global_interrupt_enable,
   input  wire                    brownout_ready,
   input  wire [`RCF_PC_W-1:0]    pc_current,
   output reg                     pc_load,
   output reg  [`RCF_PC_W-1:0]    pc_value,
   output reg                     core_reset,
   output reg                     soft_brownout_enable,
   output reg                     brownout_fast_start
);

   // Every event input, power-on included, crosses two flip-flops before
   // any logic reads it, so a pulse that is not aligned to clk_sys cannot
   // leave a flag half updated.
   reg  [9:0] sync1_reg;
   reg  [9:0] sync2_reg;
   reg  [9:0] prev_reg;
   wire [9:0] raw_in;
   wire [9:0] ev;
   reg  [7:0] cause_reg;
   reg  [7:0] cause_next;
   reg        time_out_reg;
   reg        time_out_next;
   reg        power_down_reg;
   reg        power_down_next;
   reg        stack_reset_enable_reg;
   reg        vec_pending_reg;
   reg        ready_sync1_reg;
   reg        ready_sync2_reg;
   wire       e_power_on;
   wire       e_brownout;
   wire       e_watchdog;
   wire       e_pin;
   wire       e_instr;
   wire       e_ovf;
   wire       e_unf;
   wire       e_int;
   wire       wr_cause;
   wire       stk_rst;
   wire       asleep;

   assign raw_in = {interrupt_wake_event, stack_underflow_event,
                    stack_overflow_event, reset_instr_event, pin_event,
                    watchdog_event, low_power_brownout_event, bor_event,
                    por_event, sleeping};

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg       <= 10'h000;
         sync2_reg       <= 10'h000;
         prev_reg        <= 10'h000;
         ready_sync1_reg <= 1'b0;
         ready_sync2_reg <= 1'b0;
      end else begin
         sync1_reg       <= raw_in;
         sync2_reg       <= sync1_reg;
         prev_reg        <= sync2_reg;
         ready_sync1_reg <= brownout_ready;
         ready_sync2_reg <= ready_sync1_reg;
      end
   end

   // Rising edges only, so a long reset pulse updates flags once.
   assign ev         = sync2_reg & ~prev_reg; // R22
   assign asleep     = sync2_reg[0];
   assign e_power_on = ev[1];
   assign e_brownout = ev[2] | ev[3]; // R21
   assign e_watchdog = ev[4];
   assign e_pin      = ev[5];
   assign e_instr    = ev[6];
   assign e_ovf      = ev[7];
   assign e_unf      = ev[8];
   assign e_int      = ev[9];
   assign wr_cause = reg_wr && (reg_addr == `RCF_OFF_CAUSE);
   assign stk_rst  = (e_ovf | e_unf) & stack_reset_enable_reg; // R17

   // Firmware write first, then hardware events on top, so that an event
   // in the same cycle as a write is never lost.
   always @* begin
      cause_next      = cause_reg;
      time_out_next   = time_out_reg;
      power_down_next = power_down_reg;
      if (wr_cause) begin
         cause_next = reg_wdata & `RCF_CAUSE_MASK; // R14 R20
      end
      if (reg_wr && (reg_addr == `RCF_OFF_STATUS)) begin
         time_out_next   = reg_wdata[`RCF_BIT_TIME_OUT];
         power_down_next = reg_wdata[`RCF_BIT_POWER_DOWN];
      end
      if (e_ovf) begin
         cause_next[`RCF_BIT_OVERFLOW] = 1'b1; // R15
      end
      if (e_unf) begin
         cause_next[`RCF_BIT_UNDERFLOW] = 1'b1; // R16
      end
      if (e_instr) begin
         cause_next[`RCF_BIT_INSTR] = 1'b0; // R13
      end
      if (e_pin) begin
         cause_next[`RCF_BIT_PIN] = 1'b0; // R11
         if (asleep) begin
            time_out_next   = 1'b1; // R12
            power_down_next = 1'b0; // R12
         end
      end
      if (e_int) begin
         time_out_next   = 1'b1; // R9
         power_down_next = 1'b0; // R9
      end
      if (e_watchdog) begin
         if (asleep) begin
            time_out_next   = 1'b0; // R8
            power_down_next = 1'b0; // R8
         end else begin
            cause_next[`RCF_BIT_WATCHDOG] = 1'b0; // R7
            time_out_next = 1'b0; // R7
         end
      end
      if (e_brownout) begin
         cause_next[7:6] = 2'h0; // R19
         cause_next[`RCF_BIT_WATCHDOG] = 1'b1; // R19
         cause_next[`RCF_BIT_PIN]      = 1'b1; // R19
         cause_next[`RCF_BIT_INSTR]    = 1'b1; // R19
         cause_next[`RCF_BIT_BROWNOUT] = 1'b0; // R5
         time_out_next   = 1'b1; // R1
         power_down_next = 1'b1; // R1
      end
      if (e_power_on) begin
         cause_next      = `RCF_CAUSE_POR_VAL; // R18 R4 R6
         time_out_next   = 1'b1; // R2
         power_down_next = 1'b1; // R3
      end
      cause_next[5] = 1'b0; // R20
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cause_reg              <= `RCF_CAUSE_POR_VAL; // R18
         time_out_reg           <= 1'b1; // R2
         power_down_reg         <= 1'b1; // R3
         stack_reset_enable_reg <= 1'b1;
         soft_brownout_enable   <= 1'b1;
         brownout_fast_start    <= 1'b0;
      end else begin
         cause_reg <= cause_next; // R1
         time_out_reg   <= time_out_next;
         power_down_reg <= power_down_next;
         if (reg_wr && (reg_addr == `RCF_OFF_CTRL)) begin
            stack_reset_enable_reg <= reg_wdata[`RCF_BIT_STACK_RESET];
         end
         if (reg_wr && (reg_addr == `RCF_OFF_BORCTL)) begin
            soft_brownout_enable <= reg_wdata[`RCF_BIT_SOFT_BROWN];
            brownout_fast_start  <= reg_wdata[`RCF_BIT_FAST_START];
         end
      end
   end

   // Program counter selection. A reset-class event wins over a wake-up.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc_load         <= 1'b0;
         pc_value        <= `RCF_VEC_RESET;
         core_reset      <= 1'b0;
         vec_pending_reg <= 1'b0;
      end else begin
         pc_load    <= 1'b0;
         core_reset <= 1'b0;
         if (e_power_on | e_brownout | (e_watchdog & ~asleep) | e_pin
             | e_instr | stk_rst) begin
            pc_load         <= 1'b1;
            pc_value        <= `RCF_VEC_RESET; // R7 R11 R13 R17
            core_reset      <= 1'b1;
            vec_pending_reg <= 1'b0;
         end else if ((e_watchdog & asleep) | e_int) begin
            pc_load  <= 1'b1;
            pc_value <= pc_current + 15'h0001; // R8 R9
            vec_pending_reg <= e_int & global_interrupt_enable;
         end else if (vec_pending_reg) begin
            // Next instruction already loaded; now take the vector.
            pc_load         <= 1'b1;
            pc_value        <= `RCF_VEC_INT; // R10
            vec_pending_reg <= 1'b0;
         end
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `RCF_OFF_CAUSE:  reg_rdata <= cause_reg & `RCF_CAUSE_MASK;
            `RCF_OFF_STATUS: reg_rdata <= {3'h0, time_out_reg,
                                           power_down_reg, 3'h0};
            `RCF_OFF_BORCTL: reg_rdata <= {soft_brownout_enable,
                                           brownout_fast_start, 5'h00,
                                           ready_sync2_reg};
            `RCF_OFF_CTRL:   reg_rdata <= {7'h00, stack_reset_enable_reg};
            default:         reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// ==== include/rcf_consts.vh ====
// Constants for the reset-cause flag block: offsets, bit positions,
// reset values and program counter targets.
// Assumes inclusion by bare name from the design file.
`ifndef RCF_CONSTS_VH
`define RCF_CONSTS_VH
`define RCF_ADDR_W          2
`define RCF_OFF_CAUSE       2'h0
`define RCF_OFF_STATUS      2'h1
`define RCF_OFF_BORCTL      2'h2
`define RCF_OFF_CTRL        2'h3
`define RCF_BIT_OVERFLOW    7
`define RCF_BIT_UNDERFLOW   6
`define RCF_BIT_WATCHDOG    4
`define RCF_BIT_PIN         3
`define RCF_BIT_INSTR       2
`define RCF_BIT_POR         1
`define RCF_BIT_BROWNOUT    0
`define RCF_BIT_TIME_OUT    4
`define RCF_BIT_POWER_DOWN  3
`define RCF_BIT_SOFT_BROWN  7
`define RCF_BIT_FAST_START  6
`define RCF_BIT_READY       0
`define RCF_BIT_STACK_RESET 0
`define RCF_CAUSE_MASK      8'hDF
`define RCF_CAUSE_POR_VAL   8'h1C
`define RCF_BORCTL_RST      8'h80
`define RCF_VEC_RESET       15'h0000
`define RCF_VEC_INT         15'h0004
`define RCF_PC_W            15
`endif

// ==== bench/rcf_asserts.sv ====
// Checker for the reset-cause block: event responses and read shape.
// Assumes binding to rcf_reset_cause; it sees only that module's ports.
`timescale 1ns/1ps
`include "rcf_consts.vh"
module rcf_asserts (
   input wire        clk_sys,
   input wire        rst_n,
   input wire [1:0]  reg_addr,
   input wire [7:0]  reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [7:0]  reg_rdata,
   input wire        watchdog_event,
   input wire        pin_event,
   input wire        reset_instr_event,
   input wire        stack_overflow_event,
   input wire        interrupt_wake_event,
   input wire        sleeping,
   input wire        global_interrupt_enable,
   input wire [14:0] pc_current,
   input wire        pc_load,
   input wire [14:0] pc_value,
   input wire        core_reset
);
   reg stk_en_reg;
   // Shadow of the stack reset enable, since the checker cannot see inside.
   always @(posedge clk_sys or negedge rst_n)
      if (!rst_n) stk_en_reg <= 1'h1;
      else if (reg_wr && reg_addr == `RCF_OFF_CTRL) stk_en_reg <= reg_wdata[0];
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wdt_run_reset_a:
   assert property ($rose(watchdog_event) && !sleeping |-> ##[1:4]
      core_reset && pc_load && pc_value == `RCF_VEC_RESET) else $error("wdt");
   wdt_wake_a:
   assert property ($rose(watchdog_event) && sleeping |-> ##[1:4]
      pc_load && pc_value == pc_current + 15'h1) else $error("wake pc");
   int_vector_a:
   assert property ($rose(interrupt_wake_event) && global_interrupt_enable
      |-> ##[1:4] pc_load ##1 pc_load && pc_value == `RCF_VEC_INT)
      else $error("vector");
   pin_reset_a:
   assert property ($rose(pin_event) && !sleeping |-> ##[1:4]
      core_reset && pc_value == `RCF_VEC_RESET) else $error("pin");
   instr_reset_a:
   assert property ($rose(reset_instr_event) |-> ##[1:4]
      core_reset && pc_value == `RCF_VEC_RESET) else $error("instr");
   stack_gate_a:
   assert property ($rose(stack_overflow_event) && !stk_en_reg |-> ##1
      !core_reset [*6]) else $error("stack gate");
   read_idle_a:
   assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("rdata idle");
   cause_bit5_a:
   assert property ($past(reg_rd) && $past(reg_addr) == `RCF_OFF_CAUSE
      |-> !reg_rdata[5]) else $error("bit5");
   pulse_once_a:
   assert property (core_reset |=> !core_reset) else $error("pulse");
endmodule
bind rcf_reset_cause rcf_asserts chk_u (.*);

// ==== bench/testbench.sv ====
// Self-checking bench for the reset-cause block, driven over its own bus.
// Assumes rcf_reset_cause and the constants header are compiled alongside.
`timescale 1ns/1ps
`include "rcf_consts.vh"
module testbench;
   logic        clk_sys = 1'h0, rst_n = 1'h0, reg_wr = 1'h0;
   logic        reg_rd = 1'h0, sleeping = 1'h0;
   logic [1:0]  reg_addr = 2'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [8:0]  ev = 9'h000;
   logic [14:0] pc_current = 15'h0123;
   wire  [7:0]  reg_rdata;
   wire  [14:0] pc_value;
   wire         pc_load, core_reset, soft_brownout_enable, brownout_fast_start;
   logic        global_interrupt_enable = 1'h1;
   logic [7:0]  n_loads = 8'h00, base = 8'h00;
   logic [14:0] last_pc = 15'h0000;
   wire         brownout_ready = 1'h1;
   wire         por_event = ev[0], bor_event = ev[1];
   wire         low_power_brownout_event = ev[2], watchdog_event = ev[3];
   wire         pin_event = ev[4], reset_instr_event = ev[5];
   wire         stack_overflow_event = ev[6], stack_underflow_event = ev[7];
   wire         interrupt_wake_event = ev[8];
   int          fail_count = 0, n_tests = 0;
   // Row: event, sleeping, status preset, cause expected, status expected.
   logic [31:0] rows [11] = '{
      32'h3018_0F08,
      32'h3118_1F00,
      32'h8108_1F10,
      32'h4000_1700,
      32'h4108_1710,
      32'h5018_1B18,
      32'h6018_9F18,
      32'h7018_5F18,
      32'h1000_1E18,
      32'h2000_1E18,
      32'h0000_1C18};
   rcf_reset_cause dut_u (.*);
   // Counts program counter loads and keeps the last target loaded.
   always @(posedge clk_sys) begin
      if (pc_load) begin
         n_loads <= n_loads + 8'h01;
         last_pc <= pc_value;
      end
   end
   initial forever #20 clk_sys = ~clk_sys;
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask
   task rc(input logic [1:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata & m, exp);
   endtask
   task fire(input logic [3:0] i, input logic s);
      @(posedge clk_sys);
      sleeping <= s;
      repeat (3) @(posedge clk_sys);
      ev[i] <= 1'h1;
      repeat (8) @(posedge clk_sys);
      ev[i] <= 1'h0;
      sleeping <= 1'h0;
      repeat (3) @(posedge clk_sys);
   endtask
   task wrap_up;
      if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'h1;
      rc(`RCF_OFF_CAUSE, 8'h1C, 8'hFF);
      rc(`RCF_OFF_STATUS, 8'h18, 8'h18);
      rc(`RCF_OFF_BORCTL, 8'h81, 8'hFF);
      wr(`RCF_OFF_BORCTL, 8'h40);
      rc(`RCF_OFF_BORCTL, 8'h41, 8'hFF);
      chk({6'h00, soft_brownout_enable, brownout_fast_start}, 8'h01);
      wr(`RCF_OFF_CAUSE, 8'hFF);
      rc(`RCF_OFF_CAUSE, 8'hDF, 8'hFF);
      wr(`RCF_OFF_CTRL, 8'h00);
      rc(`RCF_OFF_CTRL, 8'h00, 8'h01);
      wr(`RCF_OFF_CAUSE, 8'h1F);
      fire(4'h6, 1'h0);
      rc(`RCF_OFF_CAUSE, 8'h9F, 8'hFF);
      wr(`RCF_OFF_CTRL, 8'h01);
      foreach (rows[k]) begin
         wr(`RCF_OFF_CAUSE, 8'h1F);
         wr(`RCF_OFF_STATUS, rows[k][23:16]);
         fire(rows[k][31:28], rows[k][24]);
         rc(`RCF_OFF_CAUSE, rows[k][15:8], 8'hFF);
         rc(`RCF_OFF_STATUS, rows[k][7:0], 8'h18);
      end
      wr(`RCF_OFF_CAUSE, 8'h1F);
      rc(`RCF_OFF_CAUSE, 8'h1F, 8'hFF);
      base = n_loads;
      fire(4'h8, 1'h1);
      chk(n_loads - base, 8'h02);
      chk(last_pc[7:0], 8'h04);
      global_interrupt_enable <= 1'h0;
      base = n_loads;
      fire(4'h8, 1'h1);
      chk(n_loads - base, 8'h01);
      chk(last_pc[7:0], 8'h24);
      wrap_up();
   end
endmodule
